// ===== asr_pkg.sv
// package of constants, types and helpers for the async sram host controller
package asr_pkg;

    // =====================================================================
    // widths
    localparam int ADDR_W = 19;
    localparam int DATA_W = 16;
    localparam int CNT_W = 8;

    // =====================================================================
    // clock and pin timing in picoseconds, synchroniser depth in stages
    localparam int CLK_PERIOD_PS = 4000;
    localparam int ADDRESS_ACCESS_TIME_PS = 10000;
    localparam int READ_CYCLE_TIME_PS = 10000;
    localparam int GATE_OFF_TO_HIGHZ_PS = 5000;
    localparam int WRITE_CYCLE_TIME_PS = 10000;
    localparam int ADDRESS_TO_WRITE_END_PS = 8000;
    localparam int DATA_SETUP_TO_WRITE_END_PS = 6000;
    localparam int DATA_HOLD_AFTER_WRITE_END_PS = 0;
    localparam int SYNC_STAGES = 2;

    // least time to whole cycles, never below one
    function automatic int min_cycles(input int ps);
        int c;
        c = (ps + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
        return (c < 1) ? 1 : c;
    endfunction

    function automatic int max_int(input int a, input int b);
        return (a > b) ? a : b;
    endfunction

    // =====================================================================
    // derived cycle counts
    localparam int ACC_CYC = max_int(min_cycles(ADDRESS_ACCESS_TIME_PS),
                                     min_cycles(READ_CYCLE_TIME_PS));
    localparam int STRB_CYC = min_cycles(max_int(ADDRESS_TO_WRITE_END_PS,
                                                 DATA_SETUP_TO_WRITE_END_PS));
    localparam int HOLD_CYC = min_cycles(DATA_HOLD_AFTER_WRITE_END_PS);
    localparam int REC_CYC = max_int(1, min_cycles(WRITE_CYCLE_TIME_PS) - STRB_CYC - HOLD_CYC);
    localparam int HZ_CYC = min_cycles(GATE_OFF_TO_HIGHZ_PS);

    // =====================================================================
    // carriers
    typedef struct packed {
        logic chip_select_n;
        logic write_strobe_n;
        logic output_gate_n;
        logic upper_lane_select_n;
        logic lower_lane_select_n;
        logic [ADDR_W-1:0] address;
    } asr_pins_t;

    typedef struct packed {
        logic write;
        logic [1:0] lanes; // bit1 upper, bit0 lower, high = access lane
        logic [ADDR_W-1:0] address;
        logic [DATA_W-1:0] wdata;
    } asr_req_t;

    typedef struct packed {
        logic [DATA_W-1:0] rdata;
        logic single_bit_corrected_flag;
        logic double_bit_detected_flag;
    } asr_rsp_t;

    localparam asr_pins_t PINS_IDLE = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, {ADDR_W{1'b0}}};
    localparam asr_rsp_t RSP_RESET = '{{DATA_W{1'b0}}, 1'b0, 1'b0};

endpackage

// ===== asr_host.sv
// host controller driving an asynchronous ecc sram through its pins
`timescale 1ns/1ps
`default_nettype none
module asr_host #(
    parameter int ACC_CYCLES = asr_pkg::ACC_CYC,
    parameter int STRB_CYCLES = asr_pkg::STRB_CYC,
    parameter int HOLD_CYCLES = asr_pkg::HOLD_CYC,
    parameter int REC_CYCLES = asr_pkg::REC_CYC,
    parameter int HZ_CYCLES = asr_pkg::HZ_CYC
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic req_valid,
    input wire asr_pkg::asr_req_t req,
    output logic req_ready,
    output logic rsp_valid,
    output asr_pkg::asr_rsp_t rsp,
    output asr_pkg::asr_pins_t pins,
    output logic [asr_pkg::DATA_W-1:0] data_lines_o,
    output logic data_lines_oe,
    input wire logic [asr_pkg::DATA_W-1:0] data_lines_i,
    input wire logic single_bit_corrected_flag,
    input wire logic double_bit_detected_flag
);
    import asr_pkg::*;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_WSTROBE,
        ST_WHOLD,
        ST_WREC,
        ST_READ,
        ST_RTURN
    } asr_state_t;

    localparam logic [CNT_W-1:0] STRB_LOAD = CNT_W'(STRB_CYCLES - 1);
    localparam logic [CNT_W-1:0] HOLD_LOAD = CNT_W'(HOLD_CYCLES - 1);
    localparam logic [CNT_W-1:0] REC_LOAD = CNT_W'(REC_CYCLES - 1);
    localparam logic [CNT_W-1:0] READ_LOAD = CNT_W'(ACC_CYCLES + SYNC_STAGES - 1);
    localparam logic [CNT_W-1:0] HZ_LOAD = CNT_W'(HZ_CYCLES - 1);
    localparam int SW = DATA_W + 2;

    asr_state_t state_r, state_nxt;
    logic [CNT_W-1:0] cnt_r, cnt_nxt;
    asr_pins_t pins_r, pins_nxt;
    logic [DATA_W-1:0] dout_r, dout_nxt;
    logic doe_r, doe_nxt;
    logic rdy_r, rdy_nxt;
    logic rsp_valid_r, rsp_valid_nxt;
    asr_rsp_t rsp_r, rsp_nxt;
    logic [SW-1:0] sync1_r, sync2_r;

    // =====================================================================
    // helpers shared by the timed states

    // the state's count has run out
    function automatic logic cnt_done(input logic [CNT_W-1:0] c);
        return (c == '0);
    endfunction

    // one step down towards zero
    function automatic logic [CNT_W-1:0] cnt_step(input logic [CNT_W-1:0] c);
        return c - 1'b1;
    endfunction

    // select and both lanes go high together, address and gate kept
    function automatic asr_pins_t release_select(input asr_pins_t p);
        asr_pins_t q;
        q = p;
        q.chip_select_n = 1'b1;
        q.upper_lane_select_n = 1'b1;
        q.lower_lane_select_n = 1'b1;
        return q;
    endfunction

    // =====================================================================
    // pin input synchroniser: data lines and both error flags together
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            sync1_r <= '0;
            sync2_r <= '0;
        end else begin
            sync1_r <= {data_lines_i, single_bit_corrected_flag, double_bit_detected_flag};
            sync2_r <= sync1_r;
        end
    end

    // =====================================================================
    // sequencer next state
    always_comb begin
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        pins_nxt = pins_r;
        dout_nxt = dout_r;
        doe_nxt = doe_r;
        rdy_nxt = rdy_r;
        rsp_valid_nxt = 1'b0;
        rsp_nxt = rsp_r;
        case (state_r)
            ST_IDLE: begin
                pins_nxt = PINS_IDLE;
                pins_nxt.address = pins_r.address;
                doe_nxt = 1'b0;
                if (req_valid && rdy_r) begin
                    rdy_nxt = 1'b0;
                    // address goes out on the same edge as select, never later
                    pins_nxt.address = req.address;
                    pins_nxt.chip_select_n = 1'b0;
                    pins_nxt.upper_lane_select_n = ~req.lanes[1];
                    pins_nxt.lower_lane_select_n = ~req.lanes[0];
                    if (req.write) begin
                        // select, strobe and the requested lane selects fall together to open the window
                        pins_nxt.write_strobe_n = 1'b0;
                        pins_nxt.output_gate_n = 1'b1;
                        // safe to drive: the gate has been high for the turn time
                        dout_nxt = req.wdata;
                        doe_nxt = 1'b1;
                        cnt_nxt = STRB_LOAD;
                        state_nxt = ST_WSTROBE;
                    end else begin
                        pins_nxt.output_gate_n = 1'b0;
                        cnt_nxt = READ_LOAD;
                        state_nxt = ST_READ;
                    end
                end
            end
            ST_WSTROBE: begin
                if (cnt_done(cnt_r)) begin
                    // strobe rise ends the write; select, lanes, address, data stay
                    pins_nxt.write_strobe_n = 1'b1;
                    cnt_nxt = HOLD_LOAD;
                    state_nxt = ST_WHOLD;
                end else begin
                    cnt_nxt = cnt_step(cnt_r);
                end
            end
            ST_WHOLD: begin
                if (cnt_done(cnt_r)) begin
                    // data held past the terminating edge, then released
                    pins_nxt = release_select(pins_r);
                    doe_nxt = 1'b0;
                    cnt_nxt = REC_LOAD;
                    state_nxt = ST_WREC;
                end else begin
                    cnt_nxt = cnt_step(cnt_r);
                end
            end
            ST_WREC: begin
                // pad out the write cycle time
                if (cnt_done(cnt_r)) begin
                    rdy_nxt = 1'b1;
                    state_nxt = ST_IDLE;
                end else begin
                    cnt_nxt = cnt_step(cnt_r);
                end
            end
            ST_READ: begin
                if (cnt_done(cnt_r)) begin
                    // access time plus synchroniser depth has passed
                    rsp_nxt.rdata = sync2_r[SW-1:2];
                    rsp_nxt.single_bit_corrected_flag = sync2_r[1];
                    rsp_nxt.double_bit_detected_flag = sync2_r[0];
                    rsp_valid_nxt = 1'b1;
                    pins_nxt = release_select(pins_r);
                    pins_nxt.output_gate_n = 1'b1;
                    cnt_nxt = HZ_LOAD;
                    state_nxt = ST_RTURN;
                end else begin
                    cnt_nxt = cnt_step(cnt_r);
                end
            end
            ST_RTURN: begin
                // wait out the memory's release before anyone may drive
                if (cnt_done(cnt_r)) begin
                    rdy_nxt = 1'b1;
                    state_nxt = ST_IDLE;
                end else begin
                    cnt_nxt = cnt_step(cnt_r);
                end
            end
            default: begin
                pins_nxt = PINS_IDLE;
                doe_nxt = 1'b0;
                rdy_nxt = 1'b1;
                state_nxt = ST_IDLE;
            end
        endcase
    end

    // =====================================================================
    // sequencer registers
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            state_r <= ST_IDLE;
            cnt_r <= '0;
            pins_r <= PINS_IDLE;
            dout_r <= '0;
            doe_r <= 1'b0;
            rdy_r <= 1'b1;
            rsp_valid_r <= 1'b0;
            rsp_r <= RSP_RESET;
        end else begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            pins_r <= pins_nxt;
            dout_r <= dout_nxt;
            doe_r <= doe_nxt;
            rdy_r <= rdy_nxt;
            rsp_valid_r <= rsp_valid_nxt;
            rsp_r <= rsp_nxt;
        end
    end

    // outputs straight from flops
    assign req_ready = rdy_r;
    assign rsp_valid = rsp_valid_r;
    assign rsp = rsp_r;
    assign pins = pins_r;
    assign data_lines_o = dout_r;
    assign data_lines_oe = doe_r;

endmodule
`default_nettype wire

// ===== asr_host_chk.sv
// checker of host pin sequencing and handshake timing
`timescale 1ns/1ps
`default_nettype none
module asr_host_chk #(
    parameter int ACC_CYCLES = 3,
    parameter int STRB_CYCLES = 2,
    parameter int HOLD_CYCLES = 1,
    parameter int REC_CYCLES = 1,
    parameter int HZ_CYCLES = 2
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic req_valid,
    input wire asr_pkg::asr_req_t req,
    input wire logic req_ready,
    input wire logic rsp_valid,
    input wire asr_pkg::asr_rsp_t rsp,
    input wire asr_pkg::asr_pins_t pins,
    input wire logic [15:0] data_lines_o,
    input wire logic data_lines_oe
);
    import asr_pkg::*;
    logic wr_acc;
    logic rd_acc;
    logic [7:0] we_cnt_r;
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (rst);
    assign wr_acc = req_valid && req_ready && req.write;
    assign rd_acc = req_valid && req_ready && !req.write;
    // =====================================================================
    // strobe low cycle count
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) we_cnt_r <= 8'h00;
        else we_cnt_r <= pins.write_strobe_n ? 8'h00 : we_cnt_r + 8'h01;
    end
    // =====================================================================
    // assertions
    chk_strobe_len: assert property ($rose(pins.write_strobe_n) |-> we_cnt_r == STRB_CYCLES)
        else $error("write strobe width wrong");
    chk_write_open: assert property (wr_acc |=> !pins.chip_select_n && !pins.write_strobe_n
        && pins.output_gate_n && data_lines_oe) else $error("write window not opened");
    chk_lane_addr: assert property ((req_valid && req_ready) |=>
        {pins.upper_lane_select_n, pins.lower_lane_select_n} == ~$past(req.lanes)
        && pins.address == $past(req.address)) else $error("lanes or address wrong");
    chk_data_hold: assert property ($rose(pins.write_strobe_n) |-> !pins.chip_select_n
        && data_lines_oe && $stable(data_lines_o)) else $error("data not held at write end");
    chk_addr_steady: assert property (!pins.chip_select_n && $past(!pins.chip_select_n)
        |-> $stable(pins.address)) else $error("address moved while selected");
    chk_no_fight: assert property (data_lines_oe |-> pins.output_gate_n
        && $past(pins.output_gate_n, 2)) else $error("host drives while memory may drive");
    chk_gate_high: assert property (!pins.write_strobe_n |-> pins.output_gate_n)
        else $error("output gate low during write");
    chk_read_len: assert property (rd_acc |=> (!pins.chip_select_n && !pins.output_gate_n
        && pins.write_strobe_n)[*5] ##1 (rsp_valid && pins.chip_select_n))
        else $error("read sequence wrong");
    chk_write_len: assert property (wr_acc |=> (!pins.chip_select_n)[*3]
        ##1 pins.chip_select_n) else $error("write select span wrong");
    cov_write: cover property (wr_acc);
    cov_read: cover property (rd_acc);
    cov_flag: cover property (rsp_valid && rsp.single_bit_corrected_flag);
endmodule
`default_nettype wire

// ===== asr_mem_model.sv
// behavioural model of the asynchronous ecc sram
`timescale 1ns/1ps
`default_nettype none
module asr_mem_model (
    input wire asr_pkg::asr_pins_t pins,
    input wire logic [15:0] host_data,
    input wire logic host_oe,
    input wire logic [1:0] err_inject,
    output logic [15:0] data_lines,
    output logic sec_flag,
    output logic ded_flag
);
    import asr_pkg::*;
    logic [15:0] mem [int];
    logic drv;
    logic drv_d;
    initial begin
        data_lines = 16'h0000;
        {sec_flag, ded_flag} = 2'b00;
    end
    // drives only selected, gate low, not writing
    assign drv = !pins.chip_select_n && !pins.output_gate_n && pins.write_strobe_n;
    assign #2 drv_d = drv;
    // wire level: host, memory lanes, else inverse of last
    always @(host_oe, host_data, drv_d, pins) begin
        if (host_oe) begin
            data_lines = host_data;
        end else begin
            data_lines[15:8] = (drv_d && !pins.upper_lane_select_n) ?
                mem[pins.address][15:8] : ~data_lines[15:8];
            data_lines[7:0] = (drv_d && !pins.lower_lane_select_n) ?
                mem[pins.address][7:0] : ~data_lines[7:0];
        end
        {sec_flag, ded_flag} = drv_d ? err_inject : ~{sec_flag, ded_flag};
    end
    // store lanes during select, lane and strobe overlap
    always @(pins, data_lines) begin
        if (!pins.chip_select_n && !pins.write_strobe_n) begin
            if (!pins.upper_lane_select_n) mem[pins.address][15:8] = data_lines[15:8];
            if (!pins.lower_lane_select_n) mem[pins.address][7:0] = data_lines[7:0];
        end
    end
endmodule
`default_nettype wire

// ===== asr_host_tb.sv
// testbench of the async sram host controller
`timescale 1ns/1ps
`default_nettype none
module asr_host_tb;
    import asr_pkg::*;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic req_valid = 1'b0;
    asr_req_t req = '0;
    logic [1:0] err = 2'b00;
    logic req_ready, rsp_valid, data_lines_oe, sec, ded;
    asr_rsp_t rsp;
    asr_pins_t pins;
    logic [15:0] dout, din;
    asr_rsp_t r;
    int fails = 0;
    int n_tests = 0;
    always #2 ref_clk = ~ref_clk;
    asr_host u_asr_host (.ref_clk, .rst, .req_valid, .req, .req_ready, .rsp_valid, .rsp,
        .pins, .data_lines_o(dout), .data_lines_oe, .data_lines_i(din),
        .single_bit_corrected_flag(sec), .double_bit_detected_flag(ded));
    asr_mem_model u_asr_mem_model (.pins, .host_data(dout), .host_oe(data_lines_oe),
        .err_inject(err), .data_lines(din), .sec_flag(sec), .ded_flag(ded));
    task automatic check(string what, logic [23:0] exp, logic [23:0] got);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // one request, waits ready and for read data, bounded
    task automatic access(logic wr, logic [1:0] ln, logic [18:0] a, logic [15:0] d);
        int i;
        i = 0;
        while (i < 20 && req_ready !== 1'b1) begin
            @(posedge ref_clk);
            #1;
            i++;
        end
        if (req_ready !== 1'b1) begin
            check("req_ready in time", 24'h000001, {23'h0, req_ready});
            give_verdict();
        end
        req = '{wr, ln, a, d};
        req_valid = 1'b1;
        @(posedge ref_clk);
        #1 req_valid = 1'b0;
        i = 0;
        while (!wr && i < 20 && rsp_valid !== 1'b1) begin
            @(posedge ref_clk);
            #1;
            i++;
        end
        if (!wr && rsp_valid !== 1'b1) begin
            check("rsp_valid in time", 24'h000001, {23'h0, rsp_valid});
            give_verdict();
        end
        r = rsp;
    endtask
    task automatic t_words();
        logic [18:0] at [4] = '{19'h00000, 19'h7ffff, 19'h12345, 19'h2aaaa};
        logic [15:0] dt [4] = '{16'ha5c3, 16'h5a3c, 16'hffff, 16'h0000};
        for (int k = 0; k < 4; k++) access(1'b1, 2'b11, at[k], dt[k]);
        for (int k = 0; k < 4; k++) begin
            access(1'b0, 2'b11, at[k], 16'h0000);
            check("read word", {6'h00, dt[k], 2'b00}, {6'h00, r});
        end
    endtask
    task automatic t_lanes();
        logic [1:0] ln [4] = '{2'b11, 2'b01, 2'b10, 2'b00};
        logic [15:0] dt [4] = '{16'h1234, 16'habcd, 16'h9900, 16'h0000};
        logic [15:0] ex [4] = '{16'h1234, 16'h12cd, 16'h99cd, 16'h99cd};
        for (int k = 0; k < 4; k++) begin
            access(1'b1, ln[k], 19'h00100, dt[k]);
            access(1'b0, 2'b11, 19'h00100, 16'h0000);
            check("lane merge", {6'h00, ex[k], 2'b00}, {6'h00, r});
        end
    endtask
    task automatic t_flags();
        for (int k = 3; k >= 0; k--) begin
            err = k[1:0];
            access(1'b0, 2'b11, 19'h00100, 16'h0000);
            check("error flags", {6'h00, 16'h99cd, k[1:0]}, {6'h00, r});
        end
    endtask
    initial begin
        repeat (12) @(posedge ref_clk);
        #1 rst = 1'b0;
        check("idle pins", PINS_IDLE, pins);
        check("ready after reset", 24'h000001, {23'h0, req_ready});
        check("host drive after reset", 24'h000000, {23'h0, data_lines_oe});
        check("response after reset", 24'h000000, {5'h00, rsp_valid, rsp});
        t_words();
        t_lanes();
        t_flags();
        give_verdict();
    end
endmodule
bind asr_host asr_host_chk #(.ACC_CYCLES(ACC_CYCLES), .STRB_CYCLES(STRB_CYCLES),
    .HOLD_CYCLES(HOLD_CYCLES), .REC_CYCLES(REC_CYCLES), .HZ_CYCLES(HZ_CYCLES))
    u_chk (.ref_clk, .rst, .req_valid, .req, .req_ready, .rsp_valid, .rsp, .pins,
    .data_lines_o, .data_lines_oe);
`default_nettype wire
